/* hdl/pptc_pkg.sv */
package pptc_pkg;
    // port select codes, written as {port_select_high, port_select_low}
    localparam logic [1:0] SEL_ADDR = 2'h0;
    localparam logic [1:0] SEL_CTRL = 2'h2;
    // address register values for control-space registers
    localparam logic [7:0] IDX_CR2 = 8'h06;
    localparam logic [7:0] IDX_CR3 = 8'h07;
    localparam logic [7:0] IDX_PIX_MASK = 8'h08;
    localparam logic [7:0] IDX_PIX_TEST = 8'h09;
    localparam logic [7:0] IDX_DAC_TEST = 8'h0a;
    localparam logic [7:0] IDX_STAT_TEST = 8'h0b;
    // command register two bit positions
    localparam int CR2_POL_BIT = 0;
    localparam int CR2_RES8_BIT = 1;
    localparam int CR2_SPLIT_BIT = 2;
    // values after reset
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] CR2_RST = 8'h00;
    localparam logic [7:0] CR3_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hff;
    // widths
    localparam int PIX_W = 8;
    localparam int DAC_W = 10;
    localparam int STAT_W = 3;
    localparam int DATA_W = 10;
    // read cycle counts for the multi-cycle test registers
    localparam logic [2:0] READS_RGB = 3'h3;
    localparam logic [2:0] READS_SPLIT = 3'h6;
    // default clocks from pixel input to palette output, and default lane count
    localparam int PIPE_LAT_DEF = 4;
    localparam int LANES_DEF = 1;
endpackage

/* hdl/pptc_capture.sv */
// Notes on behaviour
// - select-low write with both selects low loads address; 06h/07h pick cr2/cr3
// - control read returns the last value written to the selected cr2, cr3 or mask register
// - capture triggers on a transition of the red top bit only
// - a command register two bit picks rising or falling trigger
// - trigger stores the triggering pixel's input rgb in the pixel test reg
// - after pipeline latency the same pixel's palette output is latched
// - captured values hold until the next trigger overwrites them
// - pixel test register is read-only, 24 bits, 8 per colour
// - pixel test register reads out in three cycles, one per colour
// - pixel test register sits right after the pixel mask register
// - output test register is read-only, 30 bits, 10 per colour
// - at 8-bit resolution the top two bits of each colour read zero
// - output test register reads in three or six cycles by byte layout
// - status test reg: bit0 sync, bit1 blank, bit2 pll, rest zero
// - status latched at the same point and time as the output capture
// - blanked triggering pixel captures all-zero colour data
// - trigger comes from pixel data only; pixel clock never stops
`timescale 1ns/10ps
`default_nettype none
module pptc_capture #(
    parameter int LANES = pptc_pkg::LANES_DEF,
    parameter int PIPE_LAT = pptc_pkg::PIPE_LAT_DEF
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic port_select_high,
    input wire logic port_select_low,
    input wire logic mpu_rd_wr,
    input wire logic mpu_stb,
    input wire logic [pptc_pkg::DATA_W-1:0] mpu_data_in,
    output logic [pptc_pkg::DATA_W-1:0] mpu_data_out,
    output logic mpu_data_oe,
    input wire logic [LANES*pptc_pkg::PIX_W-1:0] pix_red,
    input wire logic [LANES*pptc_pkg::PIX_W-1:0] pix_green,
    input wire logic [LANES*pptc_pkg::PIX_W-1:0] pix_blue,
    input wire logic [LANES*pptc_pkg::DAC_W-1:0] pal_red,
    input wire logic [LANES*pptc_pkg::DAC_W-1:0] pal_green,
    input wire logic [LANES*pptc_pkg::DAC_W-1:0] pal_blue,
    input wire logic [LANES-1:0] pal_sync_n,
    input wire logic [LANES-1:0] pal_blank_n,
    input wire logic [LANES-1:0] pal_pll_sync,
    output logic [7:0] command_register_two,
    output logic [7:0] command_register_three,
    output logic [7:0] pixel_mask
);
    import pptc_pkg::*;

    localparam int LW = (LANES > 1) ? $clog2(LANES) : 1;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] cr2;
        logic [7:0] cr3;
        logic [7:0] mask;
        logic [3*PIX_W-1:0] pix_test;
        logic [3*DAC_W-1:0] dac_test;
        logic [STAT_W-1:0] stat;
        logic prev_r7;
        logic [PIPE_LAT-1:0] dly_v;
        logic [PIPE_LAT-1:0][LW-1:0] dly_lane;
        logic [2:0] rd_idx;
        logic [DATA_W-1:0] dout;
        logic oe;
    } pptc_state_type;

    pptc_state_type st_reg;
    pptc_state_type st_next;

    // lowest lane in display order wins when several lanes toggle
    function automatic logic [LW-1:0] first_hit(
        input logic [LANES-1:0] hit
    );
        logic [LW-1:0] l;
        l = '0;
        for (int i = LANES - 1; i >= 0; i--) begin
            if (hit[i]) begin
                l = LW'(i);
            end
        end
        return l;
    endfunction

    // palette colour as the test register holds it
    function automatic logic [DAC_W-1:0] dac_colour(
        input logic [DAC_W-1:0] v,
        input logic res8,
        input logic blank_n
    );
        logic [DAC_W-1:0] c;
        c = v;
        if (res8) begin
            c[DAC_W-1:DAC_W-2] = 2'h0;
        end
        if (!blank_n) begin
            c = '0;
        end
        return c;
    endfunction

    // chain of red top bits: index 0 is the last pixel of the prior clock
    logic [LANES:0] r7_chain;
    logic [LANES-1:0] edge_hit;
    logic rise_sel;
    logic trig_any;
    logic [LW-1:0] trig_lane;
    logic [3*PIX_W-1:0] trig_pix;
    logic dly_out_v;
    logic [LW-1:0] dly_out_lane;
    logic [3*DAC_W-1:0] dac_cap;
    logic [STAT_W-1:0] stat_cap;

    assign rise_sel = st_reg.cr2[CR2_POL_BIT];

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign r7_chain[i+1] = pix_red[i*PIX_W+PIX_W-1];
        // each lane compares with the pixel before it in display order
        assign edge_hit[i] = rise_sel
            ? (r7_chain[i+1] && !r7_chain[i])
            : (!r7_chain[i+1] && r7_chain[i]);
    end
    assign r7_chain[0] = st_reg.prev_r7;

    // only pixel content triggers, so capture runs on a free clock
    assign trig_any = |edge_hit;
    assign trig_lane = first_hit(edge_hit);
    assign trig_pix = {pix_red[trig_lane*PIX_W +: PIX_W],
                       pix_green[trig_lane*PIX_W +: PIX_W],
                       pix_blue[trig_lane*PIX_W +: PIX_W]};

    // palette side of the pipeline, PIPE_LAT clocks behind the input
    assign dly_out_v = st_reg.dly_v[PIPE_LAT-1];
    assign dly_out_lane = st_reg.dly_lane[PIPE_LAT-1];
    assign dac_cap = {
        dac_colour(pal_red[dly_out_lane*DAC_W +: DAC_W],
                   st_reg.cr2[CR2_RES8_BIT],
                   pal_blank_n[dly_out_lane]),
        dac_colour(pal_green[dly_out_lane*DAC_W +: DAC_W],
                   st_reg.cr2[CR2_RES8_BIT],
                   pal_blank_n[dly_out_lane]),
        dac_colour(pal_blue[dly_out_lane*DAC_W +: DAC_W],
                   st_reg.cr2[CR2_RES8_BIT],
                   pal_blank_n[dly_out_lane])};
    assign stat_cap = {pal_pll_sync[dly_out_lane],
                       pal_blank_n[dly_out_lane],
                       pal_sync_n[dly_out_lane]};

    // next state: capture path and microprocessor port
    always_comb begin
        logic [2:0] lim;
        logic [1:0] col;
        logic [DAC_W-1:0] dv;
        st_next = st_reg;
        lim = READS_RGB;
        col = 2'h0;
        dv = '0;
        st_next.oe = 1'b0;
        st_next.prev_r7 = r7_chain[LANES];
        // delay line tracks the triggering pixel to the palette output
        st_next.dly_v = {st_reg.dly_v[PIPE_LAT-2:0], trig_any};
        st_next.dly_lane = {st_reg.dly_lane[PIPE_LAT-2:0], trig_lane};
        if (trig_any) begin
            st_next.pix_test = trig_pix;
        end
        if (dly_out_v) begin
            st_next.dac_test = dac_cap;
            st_next.stat = stat_cap;
        end
        if (mpu_stb && !mpu_rd_wr) begin
            if ({port_select_high, port_select_low} == SEL_ADDR) begin
                st_next.addr = mpu_data_in[7:0];
                st_next.rd_idx = 3'h0;
            end else if ({port_select_high, port_select_low}
                         == SEL_CTRL) begin
                // test registers are read-only; writes to them drop
                unique case (st_reg.addr)
                    IDX_CR2: st_next.cr2 = mpu_data_in[7:0];
                    IDX_CR3: st_next.cr3 = mpu_data_in[7:0];
                    IDX_PIX_MASK: st_next.mask = mpu_data_in[7:0];
                    default: ;
                endcase
            end
        end
        if (mpu_stb && mpu_rd_wr) begin
            st_next.oe = 1'b1;
            st_next.dout = '0;
            if ({port_select_high, port_select_low} == SEL_ADDR) begin
                st_next.dout = {2'h0, st_reg.addr};
            end else if ({port_select_high, port_select_low}
                         == SEL_CTRL) begin
                unique case (st_reg.addr)
                    IDX_CR2: st_next.dout = {2'h0, st_reg.cr2};
                    IDX_CR3: st_next.dout = {2'h0, st_reg.cr3};
                    IDX_PIX_MASK: st_next.dout = {2'h0, st_reg.mask};
                    IDX_PIX_TEST: begin
                        // red, green, blue on successive reads
                        col = st_reg.rd_idx[1:0];
                        st_next.dout = {2'h0,
                            st_reg.pix_test[23-8*col -: 8]};
                    end
                    IDX_DAC_TEST: begin
                        if (st_reg.cr2[CR2_SPLIT_BIT]) begin
                            // eight upper bits, then the two low bits
                            lim = READS_SPLIT;
                            col = st_reg.rd_idx[2:1];
                            dv = st_reg.dac_test[29-10*col -: 10];
                            st_next.dout = st_reg.rd_idx[0]
                                ? {8'h00, dv[1:0]}
                                : {2'h0, dv[9:2]};
                        end else begin
                            col = st_reg.rd_idx[1:0];
                            st_next.dout =
                                st_reg.dac_test[29-10*col -: 10];
                        end
                    end
                    IDX_STAT_TEST: st_next.dout =
                        {{(DATA_W-STAT_W){1'b0}}, st_reg.stat};
                    default: st_next.dout = '0;
                endcase
                // sequence counter wraps after the last component
                if (st_reg.addr == IDX_PIX_TEST
                    || st_reg.addr == IDX_DAC_TEST) begin
                    st_next.rd_idx = (st_reg.rd_idx + 3'h1 >= lim)
                        ? 3'h0 : st_reg.rd_idx + 3'h1;
                end
            end
        end
    end

    // single state register; reset gives known control and clean captures
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_reg <= '0;
            st_reg.addr <= ADDR_RST;
            st_reg.cr2 <= CR2_RST;
            st_reg.cr3 <= CR3_RST;
            st_reg.mask <= MASK_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign mpu_data_out = st_reg.dout;
    assign mpu_data_oe = st_reg.oe;
    assign command_register_two = st_reg.cr2;
    assign command_register_three = st_reg.cr3;
    assign pixel_mask = st_reg.mask;

    addr_load_a: assert property (@(posedge core_clk)
        disable iff (srst)
        mpu_stb && !mpu_rd_wr && !port_select_high && !port_select_low
        |=> st_reg.addr == $past(mpu_data_in[7:0]))
        else $error("address register did not load");

    // control write, one idle cycle, then a read of the same register
    cr_readback_a: assert property (@(posedge core_clk)
        disable iff (srst)
        mpu_stb && !mpu_rd_wr && port_select_high && !port_select_low
        && st_reg.addr == IDX_CR2
        ##1 !mpu_stb
        ##1 mpu_stb && mpu_rd_wr && port_select_high && !port_select_low
        |=> mpu_data_oe && mpu_data_out[7:0] == $past(mpu_data_in[7:0], 3))
        else $error("command register read-back mismatch");

    pix_latch_a: assert property (@(posedge core_clk)
        disable iff (srst)
        trig_any |=> st_reg.pix_test == $past(trig_pix))
        else $error("pixel test register missed trigger");

    pix_hold_a: assert property (@(posedge core_clk)
        disable iff (srst)
        !trig_any |=> $stable(st_reg.pix_test))
        else $error("pixel test register changed without trigger");

    dac_delay_a: assert property (@(posedge core_clk)
        disable iff (srst)
        trig_any |-> ##PIPE_LAT dly_out_v
        && dly_out_lane == $past(trig_lane, PIPE_LAT))
        else $error("palette capture not at pipeline latency");

    dac_latch_a: assert property (@(posedge core_clk)
        disable iff (srst)
        dly_out_v |=> st_reg.dac_test == $past(dac_cap)
        && st_reg.stat == $past(stat_cap))
        else $error("palette and status capture mismatch");

    blank_zero_a: assert property (@(posedge core_clk)
        disable iff (srst)
        dly_out_v && !pal_blank_n[dly_out_lane]
        |=> st_reg.dac_test == '0 && !st_reg.stat[1])
        else $error("blanked pixel captured nonzero colour");

    res8_zero_a: assert property (@(posedge core_clk)
        disable iff (srst)
        dly_out_v && st_reg.cr2[CR2_RES8_BIT] && $stable(st_reg.cr2)
        |=> st_reg.dac_test[29:28] == 2'h0
        && st_reg.dac_test[19:18] == 2'h0
        && st_reg.dac_test[9:8] == 2'h0)
        else $error("upper colour bits set at 8-bit resolution");

    edge_pol_a: assert property (@(posedge core_clk)
        disable iff (srst)
        trig_any |-> (pix_red[trig_lane*PIX_W+PIX_W-1] == rise_sel))
        else $error("trigger on wrong transition direction");
endmodule
`default_nettype wire

/* bench/pptc_mpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pptc_mpu_model (
    input wire logic core_clk,
    output logic port_select_high,
    output logic port_select_low,
    output logic mpu_rd_wr,
    output logic mpu_stb,
    output logic [pptc_pkg::DATA_W-1:0] mpu_data_in,
    input wire logic [pptc_pkg::DATA_W-1:0] mpu_data_out,
    input wire logic mpu_data_oe
);
    import pptc_pkg::*;
    // idle port before the first access
    initial begin
        {port_select_high, port_select_low, mpu_rd_wr, mpu_stb} = 4'h0;
        mpu_data_in = 10'h000;
    end
    // one strobe cycle per access; a released bus shows the inverse
    task automatic access(input logic [1:0] sel, input logic rd,
        input logic [9:0] din, output logic [9:0] dout, output logic ok);
        @(posedge core_clk);
        #1;
        {port_select_high, port_select_low} = sel;
        mpu_rd_wr = rd;
        mpu_stb = 1'b1;
        mpu_data_in = din;
        @(posedge core_clk);
        #1;
        mpu_stb = 1'b0;
        mpu_data_in = ~din;
        // read answer is sampled 1 ns after the edge that takes the strobe
        dout = mpu_data_out;
        ok = !rd || (mpu_data_oe === 1'b1);
    endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pptc_pkg::*;
    localparam int LAT = 4;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic psh, psl, rdwr, stb, oe;
    logic [9:0] din, dout, palr, palg, palb;
    logic [7:0] cr2o, cr3o, masko;
    logic [26:0] pix_now = 27'h0;
    logic [26:0] dly [LAT];
    int fails = 0;
    int checks = 0;
    always #4 core_clk = ~core_clk;
    // palette stand-in: fixed top bits, pixel delayed by the pipe latency
    always @(posedge core_clk) begin
        dly[0] <= pix_now;
        for (int i = 1; i < LAT; i++) dly[i] <= dly[i-1];
    end
    assign palr = {2'h2, dly[LAT-1][23:16]};
    assign palg = {2'h2, dly[LAT-1][15:8]};
    assign palb = {2'h2, dly[LAT-1][7:0]};
    pptc_mpu_model u_mpu (.core_clk(core_clk), .port_select_high(psh),
        .port_select_low(psl), .mpu_rd_wr(rdwr), .mpu_stb(stb),
        .mpu_data_in(din), .mpu_data_out(dout), .mpu_data_oe(oe));
    pptc_capture #(.LANES(1), .PIPE_LAT(LAT)) u_dut (.core_clk(core_clk),
        .srst(srst), .port_select_high(psh), .port_select_low(psl),
        .mpu_rd_wr(rdwr), .mpu_stb(stb), .mpu_data_in(din),
        .mpu_data_out(dout), .mpu_data_oe(oe), .pix_red(pix_now[23:16]),
        .pix_green(pix_now[15:8]), .pix_blue(pix_now[7:0]),
        .pal_red(palr), .pal_green(palg), .pal_blue(palb),
        .pal_sync_n(dly[LAT-1][24]), .pal_blank_n(dly[LAT-1][25]),
        .pal_pll_sync(dly[LAT-1][26]), .command_register_two(cr2o),
        .command_register_three(cr3o), .pixel_mask(masko));
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [9:0] exp,
        input logic [9:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        logic [9:0] q;
        logic ok;
        u_mpu.access(sel, 1'b0, {2'h0, d}, q, ok);
    endtask
    // a missing read answer ends the run at once
    task automatic rd_chk(input string what, input logic [9:0] exp);
        logic [9:0] q;
        logic ok;
        u_mpu.access(SEL_CTRL, 1'b1, 10'h3ff, q, ok);
        if (!ok) begin
            fails++;
            $display("mismatch %s answer expected 1 seen 0", what);
            complete_run();
        end else begin
            cmp(what, exp, q);
        end
    endtask
    task automatic put(input logic [26:0] p);
        @(posedge core_clk);
        #1;
        pix_now = p;
    endtask
    function automatic logic [9:0] dac(input logic [7:0] x,
        input logic res8, input logic bn);
        logic [9:0] c;
        c = {2'h2, x};
        if (res8) c[9:8] = 2'h0;
        if (!bn) c = 10'h000;
        return c;
    endfunction
    task automatic t_reset();
        logic [9:0] q;
        logic ok;
        wr(SEL_ADDR, IDX_CR2);
        rd_chk("cr2 reset", {2'h0, CR2_RST});
        wr(SEL_ADDR, IDX_PIX_MASK);
        rd_chk("mask reset", {2'h0, MASK_RST});
        cmp("mask port", {2'h0, MASK_RST}, {2'h0, masko});
        // the address register reads back on the address select
        u_mpu.access(SEL_ADDR, 1'b1, 10'h3ff, q, ok);
        cmp("addr answer", 10'h001, {9'h0, ok});
        cmp("addr read", {2'h0, IDX_PIX_MASK}, q);
        wr(SEL_CTRL, 8'h3c);
        rd_chk("mask write", 10'h03c);
        cmp("mask port", 10'h03c, {2'h0, masko});
        $display("test reset done");
    endtask
    task automatic t_readback();
        wr(SEL_ADDR, IDX_CR2);
        wr(SEL_CTRL, 8'he0);
        rd_chk("cr2 readback", 10'h0e0);
        wr(SEL_ADDR, IDX_CR3);
        wr(SEL_CTRL, 8'h40);
        rd_chk("cr3 readback", 10'h040);
        wr(SEL_ADDR, IDX_CR2);
        rd_chk("cr2 late read", 10'h0e0);
        cmp("cr2 port", 10'h0e0, {2'h0, cr2o});
        cmp("cr3 port", 10'h040, {2'h0, cr3o});
        $display("test readback done");
    endtask
    // prime, trigger, decoy pixel, reverse edge, then read all captures
    task automatic cap(input logic pol, input logic res8, input logic split,
        input logic [6:0] r7, input logic [7:0] g, input logic [7:0] b,
        input logic [2:0] st);
        logic [7:0] r;
        logic [9:0] v [3];
        r = {pol, r7};
        wr(SEL_ADDR, IDX_CR2);
        wr(SEL_CTRL, {5'h0, split, res8, pol});
        put({3'h7, ~pol, 7'h11, 8'h22, 8'h33});
        put({3'h7, ~pol, 7'h11, 8'h22, 8'h33});
        put({st, r, g, b});
        put({3'h7, pol, ~r7, ~g, ~b});
        put({3'h7, ~pol, 7'h00, 8'h00, 8'h00});
        repeat (LAT + 2) @(posedge core_clk);
        wr(SEL_ADDR, IDX_PIX_TEST);
        wr(SEL_CTRL, 8'h5a);
        wr(SEL_ADDR, IDX_PIX_TEST);
        rd_chk("pix red", {2'h0, r});
        rd_chk("pix green", {2'h0, g});
        rd_chk("pix blue", {2'h0, b});
        v[0] = dac(r, res8, st[1]);
        v[1] = dac(g, res8, st[1]);
        v[2] = dac(b, res8, st[1]);
        wr(SEL_ADDR, IDX_DAC_TEST);
        for (int i = 0; i < 3; i++) begin
            if (split) begin
                rd_chk("dac high", {2'h0, v[i][9:2]});
                rd_chk("dac low", {8'h0, v[i][1:0]});
            end else begin
                rd_chk("dac", v[i]);
            end
        end
        wr(SEL_ADDR, IDX_STAT_TEST);
        rd_chk("status", {7'h0, st});
        $display("test capture pol %0d done", pol);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_readback();
        cap(1'b1, 1'b0, 1'b0, 7'h35, 8'ha6, 8'h4c, 3'h3);
        cap(1'b0, 1'b1, 1'b0, 7'h5a, 8'hc3, 8'h96, 3'h6);
        cap(1'b1, 1'b0, 1'b1, 7'h6e, 8'h1f, 8'hf1, 3'h7);
        cap(1'b0, 1'b0, 1'b0, 7'h29, 8'h77, 8'h88, 3'h5);
        complete_run();
    end
endmodule
`default_nettype wire
